/* core/dasr_consts.vh */
// Constants for the dual converter serial readout control block.
// Assumes a 125 MHz system clock and a plain local register port.
// Behaviour
// - Power-down stops analog, serial port stays alive
// - Clearing power-down resumes, settings kept intact
// - Reference select: 0 internal buffer, 1 external
// - Soft reset: keep config, reinit everything else
// - Hard reset: soft reset plus defaults, osc
// - Self test after reset sets fail flag
// - Chip select fall samples, converts, drives outputs
// - Conversion timed by internal clock only
// - Result leaves in the following frame
// - MSB at select fall, shift on rising
// - Two-lane lengths 16, 18, 24, 26 pulses
// - One-lane: A then B on lane A
// - Two-lane: A on lane A, B on B
// - Boost with oversampling widens words by two
// - Native word width without boost
// - Read checksum appends eight bits
`ifndef DASR_CONSTS_VH
`define DASR_CONSTS_VH
// Register indices on the local port
`define DASR_REG_CFG1 4'h1
`define DASR_REG_CFG2 4'h2
`define DASR_REG_ALERT 4'h3
`define DASR_REG_RES_A 4'h4
`define DASR_REG_RES_B 4'h5
`define DASR_REG_SDI 4'h6
// Field positions of config_reg_one
`define DASR_C1_PD 0
`define DASR_C1_REFERENCE_SOURCE_SELECT 1
`define DASR_C1_BOOST 2
`define DASR_C1_CRCR 3
`define DASR_C1_OSEN 4
// Field positions of config_reg_two
`define DASR_C2_LANE 0
`define DASR_C2_RST_LO 1
`define DASR_C2_RST_HI 2
// Reset field codes
`define DASR_RST_SOFT 2'h1
`define DASR_RST_HARD 2'h2
// Field positions of the alert register
`define DASR_AL_SELFTEST 0
`define DASR_AL_OVERRUN 1
// Reset values
`define DASR_CFG1_RST 5'h00
`define DASR_CFG2_RST 1'h0
// Timing
`define DASR_CLK_NS 8
`define DASR_CONV_NS 190
`define DASR_CONV_CYC ((`DASR_CONV_NS+`DASR_CLK_NS-1)/`DASR_CLK_NS)
`define DASR_SELFTEST_CYC 16
`define DASR_CRC_POLY 8'h07
`endif

/* core/dasr_conv.v */
// Conversion sequencer for both converters.
// Runs only on the system clock, standing in for the internal oscillator.
`timescale 1ns/1ps
`include "dasr_consts.vh"
module dasr_conv #(
  parameter WB = 18
) (
  input wire clk_sys,
  input wire rst,
  input wire clear,
  input wire start,
  input wire [WB-1:0] sample_a,
  input wire [WB-1:0] sample_b,
  output reg busy,
  output reg done,
  output reg hold,
  output reg [WB-1:0] res_a,
  output reg [WB-1:0] res_b
);
  localparam integer CONV_INT = `DASR_CONV_CYC; // Conversion length
  localparam [7:0] CONV_CYC = CONV_INT[7:0];
  reg [7:0] cnt; // Cycles left in the conversion
  reg [WB-1:0] held_a; // Track-and-hold value A
  reg [WB-1:0] held_b; // Track-and-hold value B

  // Timer counts clk_sys only, never the serial clock
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      hold <= 1'b0;
      held_a <= {WB{1'b0}};
      held_b <= {WB{1'b0}};
      res_a <= {WB{1'b0}};
      res_b <= {WB{1'b0}};
    end else begin
      done <= 1'b0;
      hold <= 1'b0;
      if (clear) begin
        // Reset aborts any conversion in flight
        cnt <= 8'h00;
        busy <= 1'b0;
      end else if (start) begin
        held_a <= sample_a;
        held_b <= sample_b;
        hold <= 1'b1;
        busy <= 1'b1;
        cnt <= CONV_CYC;
      end else if (busy) begin
        if (cnt == 8'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          res_a <= held_a;
          res_b <= held_b;
        end
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // dasr_conv

/* core/dasr_shift.v */
// One output lane shift register, MSB first.
// Load and shift come from the same clock domain as the register.
`timescale 1ns/1ps
module dasr_shift #(
  parameter LW = 44
) (
  input wire clk_sys,
  input wire rst,
  input wire load,
  input wire [LW-1:0] word,
  input wire shift,
  output wire bit_out
);
  reg [LW-1:0] sr; // Remaining bits of the frame

  // Load wins over shift; zeros fill behind the data
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sr <= {LW{1'b0}};
    end else if (load) begin
      sr <= word;
    end else if (shift) begin
      sr <= {sr[LW-2:0], 1'b0};
    end
  end

  assign bit_out = sr[LW-1];
endmodule // dasr_shift

/* core/dasr_top.v */
// Control and serial readout of a dual simultaneous-sampling converter.
// Assumes cs_n, sclk and sdi are asynchronous pins sampled at 125 MHz,
// and that the analog side delivers parallel samples on demand.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "dasr_consts.vh"
module dasr_top #(
  parameter W = 16,
  parameter SELFTEST_CYC = `DASR_SELFTEST_CYC
) (
  input wire clk_sys,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [W+1:0] sample_a_in,
  input wire [W+1:0] sample_b_in,
  input wire selftest_error,
  output wire serial_out_a,
  output wire serial_out_a_oe,
  output wire serial_out_b_or_alarm,
  output wire serial_out_b_or_alarm_oe,
  output wire analog_power_en,
  output wire ref_buffer_en,
  output wire track_hold,
  output reg osc_reset,
  output reg fifo_flush
);
  localparam WB = W + 2; // Widest word, with boost
  localparam LW = 2 * WB + 8; // Longest lane A frame
  localparam [5:0] NW = W[5:0]; // Native width
  localparam [5:0] BW = WB[5:0]; // Boosted width
  localparam [7:0] CRC_POLY = `DASR_CRC_POLY;

  // Pin synchronisers, two flops each
  reg [2:0] sync1; // First stage, read by sync2 only
  reg [2:0] sync2; // Second stage, safe to use
  reg [2:0] sync3; // Previous value for edges
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      // Capture of one pin into the clock domain
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          // Idle levels: select high, clock low, so no false edge
          sync1[gi] <= (gi == 1) ? 1'b0 : 1'b1;
          sync2[gi] <= (gi == 1) ? 1'b0 : 1'b1;
          sync3[gi] <= (gi == 1) ? 1'b0 : 1'b1;
        end else begin
          sync1[gi] <= (gi == 0) ? cs_n : ((gi == 1) ? sclk : sdi);
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  wire cs_n_s = sync2[0]; // Synchronised chip select
  wire cs_fall = sync3[0] & ~sync2[0]; // Frame start
  wire cs_rise = ~sync3[0] & sync2[0]; // Frame end
  wire sclk_rise = ~sync3[1] & sync2[1]; // Serial shift edge
  wire sdi_s = sync2[2]; // Synchronised data in

  // Configuration state
  reg [4:0] cfg1; // config_reg_one fields
  reg lane_sel; // output_lane_select
  reg [1:0] alert; // Alert register
  reg [15:0] sdi_word; // Last bits shifted in
  reg frame; // Chip select low and port live
  reg soft_pulse; // Soft reset strobe
  reg hard_pulse; // Hard reset strobe
  reg st_run; // Self test in progress
  reg [15:0] st_cnt; // Self test cycles elapsed

  wire pd = cfg1[`DASR_C1_PD];
  wire reference_source_select = cfg1[`DASR_C1_REFERENCE_SOURCE_SELECT];
  wire crc_en = cfg1[`DASR_C1_CRCR];
  // Boost only takes effect inside a valid oversampling mode
  wire boost = cfg1[`DASR_C1_BOOST] & cfg1[`DASR_C1_OSEN];
  wire [5:0] n = boost ? BW : NW;
  wire reinit = soft_pulse | hard_pulse; // Common reset scope

  // Register writes on the local port
  wire wr_c1 = reg_wr & (reg_addr == `DASR_REG_CFG1);
  wire wr_c2 = reg_wr & (reg_addr == `DASR_REG_CFG2);
  wire wr_al = reg_wr & (reg_addr == `DASR_REG_ALERT);
  wire [1:0] rst_code = reg_wdata[`DASR_C2_RST_HI:`DASR_C2_RST_LO];

  // Conversion engine
  wire conv_busy; // Conversion underway
  wire [WB-1:0] res_a; // Latest result A
  wire [WB-1:0] res_b; // Latest result B
  // Power-down blocks new conversions, the port keeps going
  // Resets in flight refuse a new start
  wire frame_ok = ~reinit;
  wire conv_start = cs_fall & ~pd & frame_ok;

  dasr_conv #(
    .WB(WB)
  ) u_conv (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(reinit),
    .start(conv_start),
    .sample_a(sample_a_in),
    .sample_b(sample_b_in),
    .busy(conv_busy),
    .done(),
    .hold(track_hold),
    .res_a(res_a),
    .res_b(res_b)
  );

  // Config registers; hard reset restores defaults
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg1 <= `DASR_CFG1_RST;
      lane_sel <= `DASR_CFG2_RST;
    end else if (hard_pulse) begin
      cfg1 <= `DASR_CFG1_RST;
      lane_sel <= `DASR_CFG2_RST;
    end else begin
      // A write replaces all five config_reg_one fields at once
      if (wr_c1) begin
        cfg1 <= reg_wdata[4:0];
      end
      if (wr_c2) begin
        lane_sel <= reg_wdata[`DASR_C2_LANE];
      end
    end
  end

  // Reset field is self-clearing; it only fires a strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      soft_pulse <= 1'b0;
      hard_pulse <= 1'b0;
      osc_reset <= 1'b0;
      fifo_flush <= 1'b0;
    end else begin
      soft_pulse <= wr_c2 & (rst_code == `DASR_RST_SOFT);
      hard_pulse <= wr_c2 & (rst_code == `DASR_RST_HARD);
      osc_reset <= wr_c2 & (rst_code == `DASR_RST_HARD);
      // Oversampling block and its FIFO flush on either reset
      fifo_flush <= wr_c2 & ((rst_code == `DASR_RST_SOFT) |
                             (rst_code == `DASR_RST_HARD));
    end
  end

  // Self test after power-on and after hard reset
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_run <= 1'b1;
      st_cnt <= 16'h0000;
    end else if (hard_pulse) begin
      st_run <= 1'b1;
      st_cnt <= 16'h0000;
    end else if (st_run) begin
      if (st_cnt == SELFTEST_CYC[15:0] - 16'h0001) begin
        st_run <= 1'b0;
      end
      st_cnt <= st_cnt + 16'h0001;
    end
  end

  wire st_end = st_run & ~hard_pulse &
    (st_cnt == SELFTEST_CYC[15:0] - 16'h0001);
  // Loaded settings must equal defaults right after reset
  wire st_bad = selftest_error | (cfg1 != `DASR_CFG1_RST) |
    (lane_sel != `DASR_CFG2_RST);

  // Alert register: overrun set wins over clear on the same edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alert <= 2'h0;
    end else begin
      if (hard_pulse) begin
        alert[`DASR_AL_SELFTEST] <= 1'b0;
      end else if (st_end) begin
        alert[`DASR_AL_SELFTEST] <= st_bad;
      end
      // Overrun: new frame while converting
      if (cs_fall & conv_busy) begin
        alert[`DASR_AL_OVERRUN] <= 1'b1;
      end else if (reinit) begin
        alert[`DASR_AL_OVERRUN] <= 1'b0;
      end else if (wr_al & reg_wdata[`DASR_AL_OVERRUN]) begin
        alert[`DASR_AL_OVERRUN] <= 1'b0;
      end
    end
  end

  // Analog supplies follow power-down and reference select
  assign analog_power_en = ~pd;
  // Internal buffer on only for select 0, off in power-down
  assign ref_buffer_en = ~reference_source_select & ~pd & ~hard_pulse;

  // One step of the read checksum, msb first
  function [7:0] crc_step;
    input [7:0] c;
    input b;
    begin
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
    end
  endfunction

  // Checksum over the A word then the B word
  function [7:0] crc_calc;
    input [WB-1:0] a;
    input [WB-1:0] b;
    input [5:0] len;
    integer i;
    reg [7:0] c;
    begin
      c = 8'h00;
      for (i = 0; i < WB; i = i + 1) begin
        if (i < len) begin
          c = crc_step(c, a[WB-1-i]);
        end
      end
      for (i = 0; i < WB; i = i + 1) begin
        if (i < len) begin
          c = crc_step(c, b[WB-1-i]);
        end
      end
      crc_calc = c;
    end
  endfunction

  // Words left-aligned; native width drops the two low bits
  wire [WB-1:0] a_al = boost ? res_a : {res_a[WB-1:2], 2'b00};
  wire [WB-1:0] b_al = boost ? res_b : {res_b[WB-1:2], 2'b00};
  wire [7:0] crc = crc_calc(a_al, b_al, n);

  // Lane images for the next frame
  reg [LW-1:0] word_a; // Lane A image
  reg [LW-1:0] word_b; // Lane B image
  reg [LW-1:0] tmp_crc; // Checksum placed at top
  always @* begin
    word_a = {a_al, {(LW-WB){1'b0}}};
    word_b = {b_al, {(LW-WB){1'b0}}};
    tmp_crc = {crc, {(LW-8){1'b0}}};
    if (lane_sel) begin
      // One lane: A then B then checksum on lane A
      word_a = word_a | (word_b >> n);
      if (crc_en) begin
        word_a = word_a | (tmp_crc >> (n + n));
      end
    end else if (crc_en) begin
      // Two lanes: checksum follows A on lane A
      word_a = word_a | (tmp_crc >> n);
    end
  end

  // Frame state: live from select fall until select rise
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame <= 1'b0;
    end else if (reinit | cs_rise | cs_n_s) begin
      frame <= 1'b0;
    end else if (cs_fall) begin
      frame <= 1'b1;
    end
  end

  // Serial shifting only while a frame is live
  wire shift_en = frame & sclk_rise & ~cs_n_s;
  wire lane_a_bit; // Current lane A bit
  wire lane_b_bit; // Current lane B bit

  // Previous conversion's result loads at this frame's start
  dasr_shift #(
    .LW(LW)
  ) u_lane_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(cs_fall),
    .word(word_a),
    .shift(shift_en),
    .bit_out(lane_a_bit)
  );

  dasr_shift #(
    .LW(LW)
  ) u_lane_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(cs_fall),
    .word(word_b),
    .shift(shift_en),
    .bit_out(lane_b_bit)
  );

  // Host data captured on rising edges, kept for reading
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdi_word <= 16'h0000;
    end else if (reinit) begin
      sdi_word <= 16'h0000;
    end else if (shift_en) begin
      sdi_word <= {sdi_word[14:0], sdi_s};
    end
  end

  // Pins: drive only inside a frame, else released
  assign serial_out_a = frame & lane_a_bit;
  assign serial_out_a_oe = frame;
  // Lane B carries B in two-lane mode, else the alarm level
  assign serial_out_b_or_alarm = frame &
    (lane_sel ? alert[`DASR_AL_OVERRUN] : lane_b_bit);
  assign serial_out_b_or_alarm_oe = frame;

  // Read data appear in the cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `DASR_REG_CFG1: reg_rdata <= {11'h000, cfg1};
        `DASR_REG_CFG2: reg_rdata <= {15'h0000, lane_sel};
        `DASR_REG_ALERT: reg_rdata <= {12'h000, conv_busy, st_run, alert};
        `DASR_REG_RES_A: reg_rdata <= res_a[WB-1:WB-16];
        `DASR_REG_RES_B: reg_rdata <= res_b[WB-1:WB-16];
        `DASR_REG_SDI: reg_rdata <= sdi_word;
        // Unmapped indices and bits above the fields read zero
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Results are taken at the next frame start, so the sequencer's
  // done strobe is left open and only busy marks an overrun
endmodule // dasr_top

/* test/dasr_props.sv */
// Port-level assertions for the converter readout control block.
// Assumes pins are sampled by clk_sys, as the top module does.
`timescale 1ns/1ps
module dasr_props (
  input wire clk_sys,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire serial_out_a,
  input wire serial_out_a_oe,
  input wire serial_out_b_or_alarm_oe,
  input wire analog_power_en,
  input wire ref_buffer_en,
  input wire track_hold,
  input wire osc_reset,
  input wire fifo_flush
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg sclk_q; // Pin level one edge ago
  reg [3:0] since_rise; // Age of last pin rise, saturates
  // Tracks sclk rises so data changes can be tied to them
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      since_rise <= 4'hF;
    end else begin
      sclk_q <= sclk;
      if (sclk && !sclk_q) begin
        since_rise <= 4'h0;
      end else if (since_rise != 4'hF) begin
        since_rise <= since_rise + 4'h1;
      end
    end
  end
  // Reset field writes, soft and hard
  sequence soft_wr;
    reg_wr && reg_addr == 4'h2 && reg_wdata[2:1] == 2'h1;
  endsequence
  sequence hard_wr;
    reg_wr && reg_addr == 4'h2 && reg_wdata[2:1] == 2'h2;
  endsequence
  sequence cs_fall;
    cs_n ##1 !cs_n;
  endsequence
  oe_on_a: assert property (cs_fall |-> ##[2:5] serial_out_a_oe)
    else $error("lanes not driven after select fall");
  idle_off_a: assert property (cs_n [*6] |-> !serial_out_a_oe)
    else $error("lane driven while select high");
  data_gate_a: assert property (!serial_out_a_oe |-> !serial_out_a)
    else $error("lane data while released");
  lane_pair_a: assert property (serial_out_a_oe == serial_out_b_or_alarm_oe)
    else $error("lane enables differ");
  bit_step_a: assert property (serial_out_a_oe && $past(serial_out_a_oe)
    && $changed(serial_out_a) |-> since_rise inside {[1:4]})
    else $error("lane bit changed without clock rise");
  hold_start_a: assert property ($rose(serial_out_a_oe) && analog_power_en
    |-> ##[0:1] track_hold)
    else $error("no hold at frame start");
  hold_power_a: assert property (track_hold |-> analog_power_en && !cs_n)
    else $error("conversion while powered down");
  ref_off_a: assert property (!analog_power_en |-> !ref_buffer_en)
    else $error("reference on in power-down");
  soft_flush_a: assert property (soft_wr |-> ##[1:2] fifo_flush)
    else $error("soft reset without flush");
  soft_osc_a: assert property (soft_wr |-> ##1 !osc_reset [*2])
    else $error("soft reset hit oscillator");
  hard_reset_a: assert property (hard_wr
    |-> ##[1:2] (osc_reset && fifo_flush))
    else $error("hard reset incomplete");
endmodule // dasr_props
bind dasr_top dasr_props u_props (
  .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .serial_out_a(serial_out_a), .serial_out_a_oe(serial_out_a_oe),
  .serial_out_b_or_alarm_oe(serial_out_b_or_alarm_oe),
  .analog_power_en(analog_power_en), .ref_buffer_en(ref_buffer_en),
  .track_hold(track_hold), .osc_reset(osc_reset), .fifo_flush(fifo_flush)
);

/* test/dasr_host_model.sv */
// Host serial controller model: frames, clocks and captures lanes.
// Assumes the device samples these pins with its own faster clock.
`timescale 1ns/1ps
module dasr_host_model (
  output reg cs_n,
  output reg sclk,
  output reg sdi,
  input wire sa,
  input wire sa_oe,
  input wire sb,
  input wire sb_oe
);
  reg [43:0] cap_a; // Lane A bits, newest in bit 0
  reg [43:0] cap_b; // Lane B bits
  reg [15:0] sent = 16'h0000; // Last host data bits in frames
  event done; // Frame finished and settled
  // Released lanes read inverted so a stale level never matches
  wire la = sa_oe ? sa : ~sa;
  wire lb = sb_oe ? sb : ~sb;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // One frame, 64 ns clock only while selected
  task frame(input integer n);
    integer i;
    begin
      cap_a = 44'h0;
      cap_b = 44'h0;
      #3 cs_n = 1'b0; // Odd offset: phase unrelated to clk_sys
      #24;
      for (i = 0; i < n; i = i + 1) begin
        sdi = $urandom;
        sent = {sent[14:0], sdi};
        #16 cap_a = {cap_a[42:0], la};
        cap_b = {cap_b[42:0], lb};
        sclk = 1'b1;
        #32 sclk = 1'b0;
        #16;
      end
      cs_n = 1'b1;
      sdi = ~sdi;
      #200 -> done; // Gap outlasts conversion and release
    end
  endtask
  // Deliberate clock and data noise with select high
  task noise;
    repeat (20) begin
      #32 sclk = ~sclk;
      sdi = ~sdi;
    end
  endtask
endmodule // dasr_host_model

/* test/test_dual_adc_spi_readout_control.sv */
// Self-checking bench for the converter readout control block.
// Assumes the host model on the link and the local register port.
`timescale 1ns/1ps
`include "dasr_consts.vh"
module test_dual_adc_spi_readout_control;
  localparam ST = 4; // Shortened self test
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [15:0] wd = 16'h0000;
  reg wr = 1'b0;
  reg rd_s = 1'b0;
  reg [17:0] smp_a = 18'h00000; // Analog samples
  reg [17:0] smp_b = 18'h00000;
  reg st_err = 1'b0; // Self test error input
  reg [17:0] ra, rb; // Samples of the last conversion
  wire cs_n, sclk, sdi, sa, sa_oe, sb, sb_oe, apwr, refen;
  wire [15:0] rdata;
  integer n_mismatch = 0;
  integer num_checks = 0;
  integer m;
  reg [43:0] qa[$]; // Expected lane words
  reg [43:0] qb[$];
  reg [15:0] qr[$]; // Expected read data
  always #4 clk_sys = ~clk_sys;
  dasr_top #(.W(16), .SELFTEST_CYC(ST)) u_dut (.clk_sys(clk_sys),
    .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd_s), .reg_rdata(rdata),
    .sample_a_in(smp_a), .sample_b_in(smp_b), .selftest_error(st_err),
    .serial_out_a(sa), .serial_out_a_oe(sa_oe),
    .serial_out_b_or_alarm(sb), .serial_out_b_or_alarm_oe(sb_oe),
    .analog_power_en(apwr), .ref_buffer_en(refen), .track_hold(),
    .osc_reset(), .fifo_flush());
  dasr_host_model u_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sa(sa),
    .sa_oe(sa_oe), .sb(sb), .sb_oe(sb_oe));
  task check(input [63:0] nm, input [43:0] seen, input [43:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s exp %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // One-cycle strobes, changed just after the edge
  task wreg(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [3:0] a, input [15:0] e);
    begin
      qr.push_back(e);
      @(posedge clk_sys);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #1;
    end
  endtask
  task rnd;
    begin
      @(posedge clk_sys);
      smp_a <= 18'($urandom);
      smp_b <= 18'($urandom);
      #1;
    end
  endtask
  function [7:0] crc8(input [35:0] d, input integer nb);
    integer i;
    reg [7:0] r;
    begin
      r = 8'h00;
      for (i = nb - 1; i >= 0; i = i - 1)
        r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h07 : 8'h00);
      crc8 = r;
    end
  endfunction
  // Mode bits: 0 one lane, 1 checksum, 2 boost
  task xfr(input [2:0] md, input k, input cv);
    integer w, n;
    reg [17:0] ea, eb;
    reg [43:0] va, vb;
    begin
      w = md[2] ? 18 : 16;
      ea = md[2] ? ra : {2'h0, ra[17:2]};
      eb = md[2] ? rb : {2'h0, rb[17:2]};
      n = (md[0] ? 2 * w : w) + (md[1] ? 8 : 0);
      va = md[0] ? (({26'h0, ea} << w) | eb) : {26'h0, ea};
      vb = md[0] ? 44'h0 : {26'h0, eb};
      if (md[1]) begin
        va = (va << 8) | crc8(({18'h0, ea} << w) | eb, 2 * w);
        vb = vb << 8;
      end
      if (k) begin
        qa.push_back(va);
        qb.push_back(vb);
      end
      if (cv) begin
        ra = smp_a;
        rb = smp_b;
      end
      u_host.frame(n);
    end
  endtask
  // Result monitors pop the oldest note
  always @(u_host.done) begin
    if (qa.size() > 0) begin
      check("lane_a", u_host.cap_a, qa.pop_front());
      check("lane_b", u_host.cap_b, qb.pop_front());
    end
  end
  always @(posedge clk_sys) begin
    if (rd_s) begin
      #1 check("rdata", rdata, qr.pop_front());
    end
  end
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
  initial begin
    void'($urandom(32'h2FE6));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    settle(ST + 10);
    rreg(`DASR_REG_ALERT, 16'h0000);
    wreg(`DASR_REG_CFG1, 16'h0002);
    settle(2);
    check("refen", refen, 1'b0);
    wreg(`DASR_REG_CFG2, 16'h0002);
    settle(10);
    rreg(`DASR_REG_CFG1, 16'h0002);
    check("refen", refen, 1'b0);
    st_err <= 1'b1;
    wreg(`DASR_REG_CFG2, 16'h0004);
    settle(ST + 10);
    rreg(`DASR_REG_CFG1, 16'h0000);
    rreg(`DASR_REG_ALERT, 16'h0001);
    check("refen", refen, 1'b1);
    st_err <= 1'b0;
    wreg(`DASR_REG_CFG2, 16'h0004);
    settle(ST + 10);
    rreg(`DASR_REG_ALERT, 16'h0000);
    wreg(4'hF, 16'hFFFF);
    rreg(4'hF, 16'h0000);
    for (m = 0; m < 8; m = m + 1) begin
      wreg(`DASR_REG_CFG1, {11'h0, m[2], m[1], m[2], 2'h0});
      wreg(`DASR_REG_CFG2, {15'h0, m[0]});
      rnd;
      xfr(m[2:0], 1'b0, 1'b1);
      rnd;
      xfr(m[2:0], 1'b1, 1'b1);
    end
    rreg(`DASR_REG_RES_A, ra[17:2]);
    wreg(`DASR_REG_CFG1, 16'h001D);
    settle(2);
    check("apwr", apwr, 1'b0);
    check("refen", refen, 1'b0);
    rnd;
    xfr(3'h7, 1'b1, 1'b0);
    wreg(`DASR_REG_CFG1, 16'h001C);
    settle(2);
    check("apwr", apwr, 1'b1);
    rreg(`DASR_REG_CFG1, 16'h001C);
    rreg(`DASR_REG_CFG2, 16'h0001);
    settle(50);
    xfr(3'h7, 1'b1, 1'b1);
    u_host.noise;
    rreg(`DASR_REG_SDI, u_host.sent);
    settle(4);
    finish_test;
  end
endmodule // test_dual_adc_spi_readout_control
